// ---- lbg_cfg.svh ----
// Constants of the LED blink generator: register map, field positions,
// reset values and timing counts. Included by the package and the top module.
`ifndef LBG_CFG_SVH
`define LBG_CFG_SVH

// Register offsets on the 8-bit host register port
`define LBG_ADDR_LED_CONTROL 8'h00
`define LBG_ADDR_LED_CLOCK_GATE 8'h04

// Reset values
`define LBG_RST_LED_CONTROL 8'h00
`define LBG_RST_LED_CLOCK_GATE 8'h00

// Field positions of led_control
`define LBG_PERIOD_LSB 0
`define LBG_PERIOD_MSB 2
`define LBG_ON_LSB 3
`define LBG_ON_MSB 5
`define LBG_PULSE_RST_N_BIT 6
`define LBG_FORCE_LIGHT_BIT 7

// Field position of led_clock_gate
`define LBG_CLK_EN_BIT 0

// Clock rates in Hz
`define LBG_REF_CLK_HZ 50000000
`define LBG_FUNC_CLK_HZ 32768
`define LBG_TICK_HZ 256

// Blink period in internal ticks, codes 0 to 7
`define LBG_PER_0 10'h020
`define LBG_PER_1 10'h040
`define LBG_PER_2 10'h080
`define LBG_PER_3 10'h100
`define LBG_PER_4 10'h180
`define LBG_PER_5 10'h200
`define LBG_PER_6 10'h280
`define LBG_PER_7 10'h300

// LED on time in internal ticks, codes 0 to 7
`define LBG_ON_0 10'h001
`define LBG_ON_1 10'h002
`define LBG_ON_2 10'h004
`define LBG_ON_3 10'h008
`define LBG_ON_4 10'h00C
`define LBG_ON_5 10'h010
`define LBG_ON_6 10'h014
`define LBG_ON_7 10'h018

`endif

// ---- lbg_pkg.sv ----
// Types of the LED blink generator: select codes, tick counts, pulse phase.
// Assumes lbg_cfg.svh is on the include path.
`include "lbg_cfg.svh"

package lbg_pkg;

   typedef logic [2:0] lbg_sel_type;
   typedef logic [9:0] lbg_ticks_type;

   typedef enum logic [2:0]
   {
      LBG_HOLD = 3'b001,
      LBG_ON = 3'b010,
      LBG_OFF = 3'b100
   } lbg_phase_type;

   function automatic lbg_ticks_type lbg_period_ticks(input lbg_sel_type sel);
      case (sel)
         3'h0: lbg_period_ticks = `LBG_PER_0;
         3'h1: lbg_period_ticks = `LBG_PER_1;
         3'h2: lbg_period_ticks = `LBG_PER_2;
         3'h3: lbg_period_ticks = `LBG_PER_3;
         3'h4: lbg_period_ticks = `LBG_PER_4;
         3'h5: lbg_period_ticks = `LBG_PER_5;
         3'h6: lbg_period_ticks = `LBG_PER_6;
         default: lbg_period_ticks = `LBG_PER_7;
      endcase
   endfunction : lbg_period_ticks

   function automatic lbg_ticks_type lbg_on_ticks(input lbg_sel_type sel);
      case (sel)
         3'h0: lbg_on_ticks = `LBG_ON_0;
         3'h1: lbg_on_ticks = `LBG_ON_1;
         3'h2: lbg_on_ticks = `LBG_ON_2;
         3'h3: lbg_on_ticks = `LBG_ON_3;
         3'h4: lbg_on_ticks = `LBG_ON_4;
         3'h5: lbg_on_ticks = `LBG_ON_5;
         3'h6: lbg_on_ticks = `LBG_ON_6;
         default: lbg_on_ticks = `LBG_ON_7;
      endcase
   endfunction : lbg_on_ticks

endpackage : lbg_pkg

// ---- lbg_tick_div.sv ----
// Enable-pulse divider: one-cycle pulse every DIV enabled reference cycles that have i_step high.
// Assumes i_en comes from logic on the same clock.
`timescale 1ns/1ps

module lbg_tick_div
   import lbg_pkg::*;
#(
   parameter int unsigned DIV = 128
)
(
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   input wire logic i_en,
   input wire logic i_step,
   output logic o_pulse
);

   localparam int unsigned W = (DIV > 1) ? $clog2(DIV) : 1;
   localparam logic [W-1:0] LAST = W'(DIV - 1);

   logic [W-1:0] cnt_r;

   // A stopped clock restarts from a full division, never a partial one
   always_ff @(posedge i_ref_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         cnt_r <= '0;
         o_pulse <= 1'b0;
      end
      else if (!i_en)
      begin
         cnt_r <= '0;
         o_pulse <= 1'b0;
      end
      else if (i_step && (cnt_r == LAST))
      begin
         cnt_r <= '0;
         o_pulse <= 1'b1;
      end
      else if (i_step)
      begin
         cnt_r <= cnt_r + W'(1);
         o_pulse <= 1'b0;
      end
      else
      begin
         o_pulse <= 1'b0;
      end
   end

endmodule : lbg_tick_div

// ---- lbg_blink_generator.sv ----
// LED blink generator top: host register port, clock gate, dividers,
// pulse counter and indicator output.
// Assumes a host that drives the 8-bit register port on i_ref_clk and an
// LED on o_indicator_out. i_test_fast_sel may come from a pin.
`timescale 1ns/1ps
`include "lbg_cfg.svh"

module lbg_blink_generator
   import lbg_pkg::*;
#(
   parameter int unsigned REF_CLK_HZ = `LBG_REF_CLK_HZ,
   parameter int unsigned FUNC_CLK_HZ = `LBG_FUNC_CLK_HZ,
   parameter int unsigned TICK_HZ = `LBG_TICK_HZ,
   parameter int unsigned FUNC_DIV = (REF_CLK_HZ + FUNC_CLK_HZ / 2) / FUNC_CLK_HZ,
   parameter int unsigned TICK_DIV = FUNC_CLK_HZ / TICK_HZ
)
(
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   input wire logic [7:0] i_reg_addr,
   input wire logic [7:0] i_reg_wdata,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   output logic [7:0] o_reg_rdata,
   input wire logic i_test_fast_sel,
   output logic o_indicator_out
);

   logic [7:0] led_control_r;
   logic [7:0] led_clock_gate_r;
   logic [7:0] reg_rdata_r;
   logic test_sync1_r;
   logic test_sync2_r;
   logic func_en;
   logic slow_tick;
   logic tick;
   logic clk_on;
   logic pulse_counter_reset_n;
   logic force_light;
   lbg_phase_type phase_r;
   lbg_ticks_type cnt_r;
   lbg_ticks_type per_sh_r;
   lbg_ticks_type on_sh_r;
   logic indicator_r;

   assign clk_on = led_clock_gate_r[`LBG_CLK_EN_BIT];
   assign pulse_counter_reset_n = led_control_r[`LBG_PULSE_RST_N_BIT];
   assign force_light = led_control_r[`LBG_FORCE_LIGHT_BIT];

   // Host register writes; the port shares the reference clock, so any
   // access is taken at once and needs no handshake
   always_ff @(posedge i_ref_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         led_control_r <= `LBG_RST_LED_CONTROL;
         led_clock_gate_r <= `LBG_RST_LED_CLOCK_GATE;
      end
      else if (i_reg_wr)
      begin
         case (i_reg_addr)
            `LBG_ADDR_LED_CONTROL: led_control_r <= i_reg_wdata;
            `LBG_ADDR_LED_CLOCK_GATE: led_clock_gate_r <= {7'h00, i_reg_wdata[0]};
            default: ;
         endcase
      end
   end

   // Registered read data, one cycle after the read strobe.
   // Unmapped offsets read as zero so software can probe the map safely.
   // The data holds until the next read, so a slow host may sample late.
   always_ff @(posedge i_ref_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         reg_rdata_r <= 8'h00;
      end
      else if (i_reg_rd)
      begin
         case (i_reg_addr)
            `LBG_ADDR_LED_CONTROL: reg_rdata_r <= led_control_r;
            `LBG_ADDR_LED_CLOCK_GATE: reg_rdata_r <= led_clock_gate_r;
            default: reg_rdata_r <= 8'h00;
         endcase
      end
   end

   assign o_reg_rdata = reg_rdata_r;

   // Test select may arrive from a pin
   always_ff @(posedge i_ref_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         test_sync1_r <= 1'b0;
         test_sync2_r <= 1'b0;
      end
      else
      begin
         test_sync1_r <= i_test_fast_sel;
         test_sync2_r <= test_sync1_r;
      end
   end

   // Functional clock as an enable, stopped while the gate bit is clear.
   // Stopping it freezes the counter in its phase: the LED keeps its level,
   // so software should also clear the counter-run bit to darken the lamp.
   // The rounded divide gives a functional rate within a fraction of a
   // percent of nominal, which is far below what an eye can see on a blink.
   lbg_tick_div #(
      .DIV(FUNC_DIV)
   ) u_func_div (
      .i_ref_clk(i_ref_clk),
      .i_rst_n(i_rst_n),
      .i_en(clk_on),
      .i_step(1'b1),
      .o_pulse(func_en)
   );

   lbg_tick_div #(
      .DIV(TICK_DIV)
   ) u_tick_div (
      .i_ref_clk(i_ref_clk),
      .i_rst_n(i_rst_n),
      .i_en(clk_on),
      .i_step(func_en),
      .o_pulse(slow_tick)
   );

   // Test mode runs the counter on the functional clock, 128 times faster
   assign tick = test_sync2_r ? func_en : slow_tick;

   // Pulse counter; settings are sampled only when a period starts, so a
   // write mid-period never chops or stretches the pulse in flight
   always_ff @(posedge i_ref_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         phase_r <= LBG_HOLD;
         cnt_r <= 10'h000;
         per_sh_r <= `LBG_PER_0;
         on_sh_r <= `LBG_ON_0;
      end
      else if (!pulse_counter_reset_n)
      begin
         phase_r <= LBG_HOLD;
         cnt_r <= 10'h000;
      end
      else if (tick)
      begin
         case (phase_r)
            LBG_ON:
            begin
               if (cnt_r == on_sh_r)
               begin
                  phase_r <= LBG_OFF;
               end
               cnt_r <= cnt_r + 10'h001;
            end
            LBG_OFF:
            begin
               if (cnt_r == per_sh_r)
               begin
                  phase_r <= LBG_ON;
                  cnt_r <= 10'h001;
                  per_sh_r <= lbg_period_ticks(led_control_r[`LBG_PERIOD_MSB:`LBG_PERIOD_LSB]);
                  on_sh_r <= lbg_on_ticks(led_control_r[`LBG_ON_MSB:`LBG_ON_LSB]);
               end
               else
               begin
                  cnt_r <= cnt_r + 10'h001;
               end
            end
            default:
            begin
               phase_r <= LBG_ON;
               cnt_r <= 10'h001;
               per_sh_r <= lbg_period_ticks(led_control_r[`LBG_PERIOD_MSB:`LBG_PERIOD_LSB]);
               on_sh_r <= lbg_on_ticks(led_control_r[`LBG_ON_MSB:`LBG_ON_LSB]);
            end
         endcase
      end
   end

   // Registered output keeps the LED line free of decode glitches.
   // Force-light bypasses the counter entirely, so it works with the
   // functional clock gated off as well.
   always_ff @(posedge i_ref_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         indicator_r <= 1'b0;
      end
      else
      begin
         indicator_r <= force_light | (pulse_counter_reset_n & (phase_r == LBG_ON));
      end
   end

   assign o_indicator_out = indicator_r;

endmodule : lbg_blink_generator

// ---- lbg_blink_checker_assertions.sv ----
// Port checker for the LED blink generator.
// Assumes blink settings change only while the pulse circuit is held.
`timescale 1ns/1ps
module lbg_blink_checker #(parameter int unsigned FUNC_DIV = 2, parameter int unsigned TICK_DIV = 2)
(
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   input wire logic [7:0] i_reg_addr,
   input wire logic [7:0] i_reg_wdata,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   input wire logic [7:0] o_reg_rdata,
   input wire logic i_test_fast_sel,
   input wire logic o_indicator_out
);
   localparam int TK = FUNC_DIV * TICK_DIV;
   logic [7:0] ctrl_r;
   logic led_d_r;
   logic gap_ok_r;
   int lit_r;
   int gap_r;
   wire blink = ctrl_r[7:6] == 2'b01 && !i_test_fast_sel;
   wire rise = o_indicator_out && !led_d_r;
   function automatic int on_t(input logic [2:0] c);
      return c < 4 ? 1 << c : (c - 1) * 4;
   endfunction : on_t
   function automatic int per_t(input logic [2:0] c);
      return c < 4 ? 32 << c : (c - 1) * 128;
   endfunction : per_t
   // The period span is only trusted once a whole period ran on unchanged settings
   always_ff @(posedge i_ref_clk)
   begin
      led_d_r <= o_indicator_out;
      lit_r <= o_indicator_out ? lit_r + 1 : 0;
      gap_r <= rise ? 1 : gap_r + 1;
      gap_ok_r <= blink && (rise || gap_ok_r);
   end
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rst_n)
         ctrl_r <= 8'h00;
      else if (i_reg_wr && i_reg_addr == 8'h00)
         ctrl_r <= i_reg_wdata;
   end
   sequence wr_ctrl_s;
      i_reg_wr && !i_reg_rd && i_reg_addr == 8'h00;
   endsequence
   sequence rd_ctrl_s;
      i_reg_rd && !i_reg_wr && i_reg_addr == 8'h00;
   endsequence
   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (!i_rst_n);
   reset_dark_a: assert property (disable iff (1'b0) !i_rst_n |-> !o_indicator_out
      && o_reg_rdata == 8'h00) else $error("outputs not cleared in reset");
   unmapped_read_a: assert property (i_reg_rd && i_reg_addr != 8'h00 &&
      i_reg_addr != 8'h04 |=> o_reg_rdata == 8'h00) else $error("unmapped read not zero");
   ctrl_readback_a: assert property (wr_ctrl_s ##1 !i_reg_wr ##1 rd_ctrl_s |=>
      o_reg_rdata == $past(i_reg_wdata, 3)) else $error("control readback differs");
   gate_bits_a: assert property (i_reg_rd && i_reg_addr == 8'h04 |=>
      o_reg_rdata[7:1] == 7'h00) else $error("clock gate upper bits set");
   force_on_a: assert property (wr_ctrl_s and i_reg_wdata[7] |-> ##2 o_indicator_out)
      else $error("forced light missing");
   hold_dark_a: assert property (ctrl_r[7:6] == 2'b00 && $past(ctrl_r[7:6]) == 2'b00
      |-> !o_indicator_out) else $error("light while held");
   lit_width_a: assert property ($fell(o_indicator_out) && blink |->
      lit_r == on_t(ctrl_r[5:3]) * TK) else $error("on time wrong");
   period_len_a: assert property (rise && blink && gap_ok_r |->
      gap_r == per_t(ctrl_r[2:0]) * TK) else $error("period wrong");
endmodule : lbg_blink_checker

bind lbg_blink_generator lbg_blink_checker #(.FUNC_DIV(FUNC_DIV), .TICK_DIV(TICK_DIV))
   lbg_blink_checker_inst (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_reg_addr(i_reg_addr),
   .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
   .o_reg_rdata(o_reg_rdata), .i_test_fast_sel(i_test_fast_sel),
   .o_indicator_out(o_indicator_out));

// ---- lbg_led_model.sv ----
// Lamp model: measures each lit span and the spacing of light-up moments.
// Assumes the lamp is lit while its drive is high; i_clear restarts measuring.
`timescale 1ns/1ps
module lbg_led_model
(
   input wire logic i_ref_clk,
   input wire logic i_clear,
   input wire logic i_led,
   output int o_lit,
   output int o_per,
   output logic o_done
);
   logic prev_r = 1'b0;
   logic armed_r = 1'b0;
   int cnt_r = 0;
   int hi_r = 0;
   always @(posedge i_ref_clk)
   begin
      prev_r <= i_led;
      o_done <= armed_r && i_led && !prev_r && !i_clear;
      cnt_r <= cnt_r + 1;
      hi_r <= hi_r + i_led;
      // Light-up starts a period; report the span just finished
      if (i_led && !prev_r)
      begin
         o_per <= cnt_r;
         o_lit <= hi_r;
         cnt_r <= 1;
         hi_r <= 1;
         armed_r <= !i_clear;
      end
      if (i_clear)
         armed_r <= 1'b0;
   end
endmodule : lbg_led_model

// ---- lbg_blink_generator_tb.sv ----
// Self-checking bench for the LED blink generator with a lamp model.
// Assumes shortened dividers: one tick every four reference cycles.
`timescale 1ns/1ps
module lbg_blink_generator_tb;
   localparam int unsigned FD = 2;
   localparam int unsigned TD = 2;
   int per_tab[8] = '{32, 64, 128, 256, 384, 512, 640, 768};
   int on_tab[8] = '{1, 2, 4, 8, 12, 16, 20, 24};
   logic clk = 1'b0;
   logic rst_n = 1'b1;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic rd_seen = 1'b0;
   logic fast = 1'b0;
   logic mclr = 1'b1;
   logic [7:0] rdata;
   logic led;
   logic done;
   int lit;
   int per;
   int miscompares = 0;
   int n_compared = 0;
   int cycles = 0;
   logic [15:0] lfsr = 16'h29A3;
   logic [7:0] rd_q[$];
   int led_q[$];
   always #10 clk = ~clk;
   lbg_blink_generator #(.FUNC_DIV(FD), .TICK_DIV(TD)) lbg_blink_generator_inst (
      .i_ref_clk(clk), .i_rst_n(rst_n), .i_reg_addr(addr), .i_reg_wdata(wdata),
      .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata), .i_test_fast_sel(fast),
      .o_indicator_out(led));
   lbg_led_model lbg_led_model_inst (.i_ref_clk(clk), .i_clear(mclr), .i_led(led),
      .o_lit(lit), .o_per(per), .o_done(done));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask : check
   task automatic report_and_stop;
      $display("compared %0d miscompares %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : report_and_stop
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      #2;
      addr = a;
      wdata = d;
      wr = 1'b1;
      @(posedge clk);
      #2;
      wr = 1'b0;
   endtask : wr_reg
   task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk);
      #2;
      addr = a;
      rd = 1'b1;
      rd_q.push_back(e);
      @(posedge clk);
      #2;
      rd = 1'b0;
   endtask : rd_reg
   // Measures the first whole period after leaving hold
   task automatic blink(input int c, input int tk);
      int n;
      wr_reg(8'h00, 8'h00);
      led_q.push_back(per_tab[c] * tk);
      led_q.push_back(on_tab[c] * tk);
      wr_reg(8'h00, {2'b01, c[2:0], c[2:0]});
      mclr = 1'b0;
      for (n = 0; n < 12000 && led_q.size() > 0; n++)
         @(posedge clk);
      #2;
      mclr = 1'b1;
      check(led_q.size(), 0);
      wr_reg(8'h00, 8'h00);
   endtask : blink
   always @(posedge clk)
   begin
      #1;
      if (rd_seen)
         check(rdata, rd_q.pop_front());
      if (done === 1'b1)
      begin
         check(per, led_q.pop_front());
         check(lit, led_q.pop_front());
      end
      rd_seen = rd;
      cycles++;
      if (cycles == 60000)
      begin
         miscompares++;
         report_and_stop();
      end
   end
   initial
   begin
      // A real falling edge, so the asynchronous clear acts before the first clock
      #1;
      rst_n = 1'b0;
      repeat (2) @(posedge clk);
      #2;
      rst_n = 1'b1;
      rd_reg(8'h00, 8'h00);
      rd_reg(8'h04, 8'h00);
      for (int i = 0; i < 6; i++)
      begin
         lfsr = {1'b0, lfsr[15:1]} ^ (lfsr[0] ? 16'hB400 : 16'h0000);
         wr_reg(8'h00, lfsr[7:0] & 8'hBF);
         rd_reg(8'h00, lfsr[7:0] & 8'hBF);
         wr_reg(8'h04, lfsr[15:8]);
         rd_reg(8'h04, {7'h00, lfsr[8]});
         wr_reg(lfsr[15:8] | 8'h08, lfsr[7:0]);
         rd_reg(lfsr[15:8] | 8'h08, 8'h00);
      end
      wr_reg(8'h04, 8'h00);
      wr_reg(8'h00, 8'h40);
      repeat (200) @(posedge clk);
      #2;
      check(led, 1'b0);
      wr_reg(8'h04, 8'h01);
      for (int c = 0; c < 8; c++)
         blink(c, FD * TD);
      fast = 1'b1;
      blink(1, FD);
      fast = 1'b0;
      wr_reg(8'h00, 8'h3F);
      repeat (40) @(posedge clk);
      #2;
      check(led, 1'b0);
      rd_reg(8'h00, 8'h3F);
      wr_reg(8'h00, 8'hBF);
      repeat (2) @(posedge clk);
      #2;
      check(led, 1'b1);
      rst_n = 1'b0;
      #3;
      check(led, 1'b0);
      repeat (2) @(posedge clk);
      #2;
      rst_n = 1'b1;
      rd_reg(8'h00, 8'h00);
      rd_reg(8'h04, 8'h00);
      report_and_stop();
   end
endmodule : lbg_blink_generator_tb
